// ### design/tpm_pkg.sv
package tpm_pkg;
	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 8; // byte address width seen by the slave
	localparam logic [7:0] OFF_CTRL = 8'h00; // mode, start flag, measurement select
	localparam logic [7:0] OFF_RELOAD = 8'h04; // reload / pwm high width
	localparam logic [7:0] OFF_STATUS = 8'h08; // interrupt request, write one to clear
	localparam logic [7:0] OFF_MASK = 8'h0c; // interrupt enable
	localparam logic [7:0] OFF_COUNT = 8'h10; // live counter, read only
	localparam logic [7:0] OFF_CAPTURE = 8'h14; // measured count, read only

	// ------------------------------------------------------------
	// control field layout
	// ------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0; // two bits of operating mode
	localparam int CTRL_START_BIT = 2; // count start flag
	localparam int CTRL_MSEL_BIT = 3; // 0 period, 1 width measurement
	localparam int REQ_BIT = 0; // request bit in status and mask

	// ------------------------------------------------------------
	// operating modes
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_TIMER = 2'h0; // count clocks down
	localparam logic [1:0] MODE_EVENT = 2'h1; // count pin rising edges down
	localparam logic [1:0] MODE_PWM = 2'h2; // pulse output on the pin
	localparam logic [1:0] MODE_MEASURE = 2'h3; // period or width capture

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [1:0] RST_MODE = MODE_TIMER;
	localparam logic [15:0] RST_RELOAD = 16'h0000;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001; // counter step
endpackage : tpm_pkg

// ### design/tpm_sync.sv
// two flop synchroniser for the pin input; only the second flop is read
module tpm_sync (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic async_in,
	output logic sync_out
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic meta; // first stage, read by the second stage only
		logic stable; // second stage
	} tpm_sync_s;

	tpm_sync_s s;
	tpm_sync_s next_s;

	// shift the pin through both stages
	always_comb begin
		next_s = s;
		next_s.meta = async_in;
		next_s.stable = s.meta;
	end

	// register with synchronous reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sync_out = s.stable;
endmodule : tpm_sync

// ### design/tpm_timer.sv
// Notes on behaviour
// - pwm selection from timer/event mode raises request
// - clearing start during pwm halts counter
// - halt with pin high: pin low, request
// - halt with pin low: pin low, no request
// - measurement select change while counting raises request
// - first measured edge captures junk, no request
module tpm_timer (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	input wire logic timer_io_pin_i,
	output logic timer_io_pin_o,
	output logic timer_io_pin_oe
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic ack; // wishbone acknowledge
		logic [31:0] dat; // read data
		logic [1:0] mode; // operating mode
		logic start; // count start flag
		logic msel; // measurement select
		logic [15:0] reload; // reload or pwm high width
		logic [15:0] cnt; // working counter
		logic [15:0] capture; // last measured count
		logic req; // sticky interrupt request
		logic mask; // interrupt enable
		logic irq; // registered interrupt line
		logic pin_out; // pin drive level
		logic pin_oe; // pin drive enable
		logic pin_prev; // synchronised pin, one cycle old
		logic first_edge; // next measured edge is the first one
	} tpm_timer_s;

	tpm_timer_s s;
	tpm_timer_s next_s;
	logic pin_sync; // pin after two flops
	logic access; // bus cycle taken this clock
	logic wr_ctrl; // control write this clock
	logic [1:0] new_mode; // mode being written
	logic new_start; // start flag being written
	logic new_msel; // select being written
	logic pin_rise; // rising edge on synchronised pin
	logic pin_fall; // falling edge on synchronised pin

	tpm_sync u_tpm_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.async_in(timer_io_pin_i),
		.sync_out(pin_sync)
	);

	// ------------------------------------------------------------
	// bus decode helpers
	// ------------------------------------------------------------
	// only the lowest byte lane carries control, so it gates the write
	assign access = wb_cyc_i && wb_stb_i && !s.ack;
	assign wr_ctrl = access && wb_we_i && wb_sel_i[0] && (wb_adr_i == tpm_pkg::OFF_CTRL);
	assign new_mode = wb_dat_i[tpm_pkg::CTRL_MODE_LSB +: 2];
	assign new_start = wb_dat_i[tpm_pkg::CTRL_START_BIT];
	assign new_msel = wb_dat_i[tpm_pkg::CTRL_MSEL_BIT];
	assign pin_rise = pin_sync && !s.pin_prev;
	assign pin_fall = !pin_sync && s.pin_prev;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic set_req; // hardware event this clock
		logic clr_req; // software clear this clock
		logic edge_hit; // measured edge this clock
		set_req = 1'b0;
		clr_req = 1'b0;
		edge_hit = 1'b0;
		next_s = s;
		next_s.ack = access;
		next_s.pin_prev = pin_sync;
		// counting, skipped in the cycle of a control write
		if (s.start && !wr_ctrl) begin
			case (s.mode)
				tpm_pkg::MODE_TIMER: begin
					if (s.cnt == tpm_pkg::RST_COUNT) begin
						next_s.cnt = s.reload;
						set_req = 1'b1;
					end else begin
						next_s.cnt = s.cnt - tpm_pkg::CNT_ONE;
					end
				end
				tpm_pkg::MODE_EVENT: begin
					if (pin_rise) begin
						if (s.cnt == tpm_pkg::RST_COUNT) begin
							next_s.cnt = s.reload;
							set_req = 1'b1;
						end else begin
							next_s.cnt = s.cnt - tpm_pkg::CNT_ONE;
						end
					end
				end
				tpm_pkg::MODE_PWM: begin
					// high while the free running count is below the width
					next_s.cnt = s.cnt + tpm_pkg::CNT_ONE;
					next_s.pin_out = (s.cnt < s.reload);
					if (s.pin_out && !next_s.pin_out) begin
						set_req = 1'b1;
					end
				end
				default: begin
					// width mode takes both edges, period mode rising only
					edge_hit = s.msel ? (pin_rise || pin_fall) : pin_rise;
					if (edge_hit) begin
						next_s.capture = s.cnt;
						next_s.cnt = tpm_pkg::RST_COUNT;
						next_s.first_edge = 1'b0;
						// the first capture holds a meaningless count
						set_req = !s.first_edge;
					end else begin
						next_s.cnt = s.cnt + tpm_pkg::CNT_ONE;
					end
				end
			endcase
		end
		// register writes and read data
		next_s.dat = 32'h0000_0000;
		if (access && wb_we_i) begin
			if (wr_ctrl) begin
				next_s.mode = new_mode;
				next_s.start = new_start;
				next_s.msel = new_msel;
				// entering pwm from timer or event counting
				if (new_mode == tpm_pkg::MODE_PWM && !s.mode[1]) begin
					set_req = 1'b1;
				end
				// stopping pwm halts the counter and drops the pin
				if (s.mode == tpm_pkg::MODE_PWM && s.start && !new_start) begin
					next_s.pin_out = 1'b0;
					set_req = s.pin_out;
				end
				// select flipped while measuring
				if (s.mode == tpm_pkg::MODE_MEASURE && s.start && new_msel != s.msel) begin
					set_req = 1'b1;
				end
				// a fresh start loads the counter
				if (new_start && !s.start) begin
					next_s.cnt = (new_mode[1]) ? tpm_pkg::RST_COUNT : s.reload;
					next_s.first_edge = 1'b1;
				end
			end else if (wb_adr_i == tpm_pkg::OFF_RELOAD) begin
				if (wb_sel_i[0]) begin
					next_s.reload[7:0] = wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					next_s.reload[15:8] = wb_dat_i[15:8];
				end
			end else if (wb_adr_i == tpm_pkg::OFF_STATUS) begin
				clr_req = wb_sel_i[0] && wb_dat_i[tpm_pkg::REQ_BIT];
			end else if (wb_adr_i == tpm_pkg::OFF_MASK) begin
				if (wb_sel_i[0]) begin
					next_s.mask = wb_dat_i[tpm_pkg::REQ_BIT];
				end
			end
		end else if (access) begin
			if (wb_adr_i == tpm_pkg::OFF_CTRL) begin
				next_s.dat[tpm_pkg::CTRL_MODE_LSB +: 2] = s.mode;
				next_s.dat[tpm_pkg::CTRL_START_BIT] = s.start;
				next_s.dat[tpm_pkg::CTRL_MSEL_BIT] = s.msel;
			end else if (wb_adr_i == tpm_pkg::OFF_RELOAD) begin
				next_s.dat[15:0] = s.reload;
			end else if (wb_adr_i == tpm_pkg::OFF_STATUS) begin
				next_s.dat[tpm_pkg::REQ_BIT] = s.req;
			end else if (wb_adr_i == tpm_pkg::OFF_MASK) begin
				next_s.dat[tpm_pkg::REQ_BIT] = s.mask;
			end else if (wb_adr_i == tpm_pkg::OFF_COUNT) begin
				next_s.dat[15:0] = s.cnt;
			end else if (wb_adr_i == tpm_pkg::OFF_CAPTURE) begin
				next_s.dat[15:0] = s.capture;
			end
		end
		// the pin is driven only in pwm mode
		next_s.pin_oe = (next_s.mode == tpm_pkg::MODE_PWM);
		if (!next_s.pin_oe) begin
			next_s.pin_out = 1'b0;
		end
		// set beats clear so no event is lost
		next_s.req = set_req || (s.req && !clr_req);
		next_s.irq = next_s.req && next_s.mask;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s <= '0;
			s.mode <= tpm_pkg::RST_MODE;
			s.reload <= tpm_pkg::RST_RELOAD;
			s.cnt <= tpm_pkg::RST_COUNT;
		end else begin
			s <= next_s;
		end
	end

	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign irq = s.irq;
	assign timer_io_pin_o = s.pin_out;
	assign timer_io_pin_oe = s.pin_oe;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_pwm_entry_req: assert property (
		wr_ctrl && new_mode == tpm_pkg::MODE_PWM && !s.mode[1] |=> s.req)
		else $error("pwm entry did not raise request");
	a_pwm_halt_hold: assert property (
		s.mode == tpm_pkg::MODE_PWM && !s.start && !wr_ctrl |=> $stable(s.cnt))
		else $error("halted pwm counter moved");
	a_halt_high_drop: assert property (
		wr_ctrl && s.mode == tpm_pkg::MODE_PWM && s.start && !new_start && s.pin_out
		|=> !timer_io_pin_o && s.req)
		else $error("halt from high did not drop pin and request");
	a_halt_low_quiet: assert property (
		wr_ctrl && s.mode == tpm_pkg::MODE_PWM && s.start && !new_start && !s.pin_out
		&& !s.req && new_mode == tpm_pkg::MODE_PWM |=> !timer_io_pin_o && !s.req)
		else $error("halt from low changed pin or request");
	a_msel_change_req: assert property (
		wr_ctrl && s.mode == tpm_pkg::MODE_MEASURE && s.start && new_msel != s.msel
		|=> s.req)
		else $error("select change did not raise request");
	a_first_edge_quiet: assert property (
		s.mode == tpm_pkg::MODE_MEASURE && s.start && s.first_edge && pin_rise
		&& !s.req && !access |=> !s.req && !s.first_edge)
		else $error("first measured edge raised request");
	a_irq_follows: assert property (irq == (s.req && s.mask))
		else $error("interrupt line disagrees with request and mask");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge held over two cycles");
	a_pin_idle_low: assert property (!timer_io_pin_oe |-> !timer_io_pin_o)
		else $error("pin driven level outside pwm");

	c_pwm_stop_high: cover property (
		wr_ctrl && s.mode == tpm_pkg::MODE_PWM && s.start && !new_start && s.pin_out);
	c_capture: cover property (
		s.mode == tpm_pkg::MODE_MEASURE && s.start && !s.first_edge && pin_rise);
	c_msel_change: cover property (
		wr_ctrl && s.mode == tpm_pkg::MODE_MEASURE && s.start && new_msel != s.msel);
endmodule : tpm_timer

// ### test/timer_pwm_and_pulse_measure_tb.sv
// ------------------------------------------------------------
// self-checking bench for the timer channel
// ------------------------------------------------------------
`define CHK(a, b) begin \
	total_checks++; \
	if ((a) !== (b)) begin \
		n_fail++; \
		$display("unexpected at %0t: got %h want %h", $time, (a), (b)); \
	end \
end
module timer_pwm_and_pulse_measure_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0; // 40 MHz system clock
	logic reset = 1'b1; // sync reset, held four cycles
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // wishbone request
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0, rdat, q;
	logic ack, irq, pin_o, pin_oe, src, pin;
	logic src_en = 1'b0; // pulse train on/off
	int n_fail = 0, total_checks = 0, cycles = 0;

	always #12.5 clk_sys = ~clk_sys;
	// wire level: the channel wins while it drives, else the source
	assign pin = pin_oe ? pin_o : src;

	tpm_timer u_tpm_timer (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq(irq), .timer_io_pin_i(pin), .timer_io_pin_o(pin_o),
		.timer_io_pin_oe(pin_oe));
	tpm_pulse_src u_tpm_pulse_src (.clk_sys(clk_sys), .en(src_en), .period(8'h14),
		.high(8'h08), .src(src));

	task finish_test;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	// hang guard; the whole run needs well under two thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			$display("unexpected at %0t: run timed out", $time);
			finish_test();
		end
	end

	// one classic cycle: hold everything until ack is sampled high
	// no wait count of its own; a slave that never answers ends in the run timeout
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		do begin
			@(posedge clk_sys);
		end while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, q);
	endtask : wr

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		`CHK(r, exp)
	endtask : rd_chk

	task ctrl(input logic [1:0] m, input logic st, input logic ms);
		wr(tpm_pkg::OFF_CTRL, {28'h0, ms, st, m});
	endtask : ctrl

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset;
		rd_chk(tpm_pkg::OFF_CTRL, 32'h0);
		rd_chk(tpm_pkg::OFF_STATUS, 32'h0);
		rd_chk(tpm_pkg::OFF_MASK, 32'h0);
		rd_chk(8'h20, 32'h0); // unmapped reads zero
		`CHK(irq, 1'b0)
	endtask : t_reset

	// entering pwm from timer (first select after reset too) and from event
	task t_pwm_select;
		for (int i = 0; i < 2; i++) begin
			ctrl(i == 0 ? tpm_pkg::MODE_TIMER : tpm_pkg::MODE_EVENT, 1'b0, 1'b0);
			wr(tpm_pkg::OFF_STATUS, 32'h1);
			ctrl(tpm_pkg::MODE_PWM, 1'b0, 1'b0);
			rd_chk(tpm_pkg::OFF_STATUS, 32'h1);
		end
		wr(tpm_pkg::OFF_MASK, 32'h1);
		@(negedge clk_sys);
		`CHK(irq, 1'b1)
		wr(tpm_pkg::OFF_STATUS, 32'h1);
		@(negedge clk_sys);
		`CHK(irq, 1'b0)
	endtask : t_pwm_select

	// halt while the pin is high: counter frozen, pin low, request raised
	task t_halt_high;
		logic [31:0] c1;
		wr(tpm_pkg::OFF_RELOAD, 32'h8000);
		ctrl(tpm_pkg::MODE_PWM, 1'b1, 1'b0);
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK(pin_o, 1'b1)
		`CHK(pin_oe, 1'b1)
		ctrl(tpm_pkg::MODE_PWM, 1'b0, 1'b0);
		wb(1'b0, tpm_pkg::OFF_COUNT, 32'h0, c1);
		rd_chk(tpm_pkg::OFF_COUNT, c1);
		`CHK(pin_o, 1'b0)
		rd_chk(tpm_pkg::OFF_STATUS, 32'h1);
	endtask : t_halt_high

	// halt while the pin is low: pin stays low, no request
	task t_halt_low;
		wr(tpm_pkg::OFF_RELOAD, 32'h0);
		wr(tpm_pkg::OFF_STATUS, 32'h1);
		ctrl(tpm_pkg::MODE_PWM, 1'b1, 1'b0);
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK(pin_o, 1'b0)
		ctrl(tpm_pkg::MODE_PWM, 1'b0, 1'b0);
		`CHK(pin_o, 1'b0)
		rd_chk(tpm_pkg::OFF_STATUS, 32'h0);
	endtask : t_halt_low

	// period capture with a twenty-cycle source, then a select change
	task t_measure;
		logic [31:0] cap;
		ctrl(tpm_pkg::MODE_MEASURE, 1'b0, 1'b0);
		wr(tpm_pkg::OFF_STATUS, 32'h1);
		ctrl(tpm_pkg::MODE_MEASURE, 1'b1, 1'b0);
		src_en <= 1'b1;
		@(posedge src);
		repeat (5) @(posedge clk_sys);
		rd_chk(tpm_pkg::OFF_STATUS, 32'h0);
		@(posedge src);
		repeat (5) @(posedge clk_sys);
		rd_chk(tpm_pkg::OFF_STATUS, 32'h1);
		wb(1'b0, tpm_pkg::OFF_CAPTURE, 32'h0, cap);
		`CHK(cap, 32'h13) // twenty clock period less one
		src_en <= 1'b0;
		repeat (6) @(posedge clk_sys);
		wr(tpm_pkg::OFF_STATUS, 32'h1);
		rd_chk(tpm_pkg::OFF_STATUS, 32'h0);
		ctrl(tpm_pkg::MODE_MEASURE, 1'b1, 1'b1);
		rd_chk(tpm_pkg::OFF_STATUS, 32'h1);
		// width mode: the falling edge captures the eight clock high time less one
		src_en <= 1'b1;
		@(negedge src);
		repeat (5) @(posedge clk_sys);
		wb(1'b0, tpm_pkg::OFF_CAPTURE, 32'h0, cap);
		`CHK(cap, 32'h7)
		src_en <= 1'b0;
	endtask : t_measure

	initial begin
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset();
		t_pwm_select();
		t_halt_high();
		t_halt_low();
		t_measure();
		finish_test();
	end
endmodule : timer_pwm_and_pulse_measure_tb

// ### test/tpm_pulse_src.sv
// ------------------------------------------------------------
// external pulse source driving the timer pin
// ------------------------------------------------------------
module tpm_pulse_src (
	input wire logic clk_sys,
	input wire logic en,
	input wire logic [7:0] period,
	input wire logic [7:0] high,
	output logic src
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ph; // phase within one pulse period

	// phase counter; held at zero while idle so a new train starts with a rise
	always @(posedge clk_sys) begin
		if (!en || ph == period - 8'h01) begin
			ph <= 8'h00;
		end else begin
			ph <= ph + 8'h01;
		end
	end

	// source drives low when idle, it never floats the pin
	assign src = en && (ph < high);
endmodule : tpm_pulse_src
